// *** hw/rsrb_top.sv ***
// rsrb_top: read-only radio status bank behind the serial register port.
// assumes: status inputs are on sys_clk; port pins come from the host.
`timescale 1ns/1ps
module rsrb_top (
	input  wire logic                         sys_clk,
	input  wire logic                         rst_n,
	input  wire logic                         chip_select_low,
	input  wire logic                         spi_sclk,
	input  wire logic                         spi_mosi,
	output logic                              spi_miso_out,
	output logic                              spi_miso_oe,
	output logic                              wake_to_idle,
	input  wire logic [rsrb_pkg::CODE_W-1:0]  radio_fsm_code,
	input  wire logic [15:0]                  wor_time,
	input  wire logic                         crc_check_done,
	input  wire logic                         crc_check_match,
	input  wire logic                         carrier_sense,
	input  wire logic                         preamble_quality_met,
	input  wire logic                         channel_clear_flag,
	input  wire logic                         sync_found_flag,
	input  wire logic                         gp_output_two_level,
	input  wire logic                         gp_output_zero_level,
	input  wire logic [rsrb_pkg::BYTE_W-1:0]  synth_cal_dac,
	input  wire logic                         tx_queue_underrun,
	input  wire logic [rsrb_pkg::COUNT_W-1:0] tx_queue_count,
	input  wire logic                         rx_queue_overrun,
	input  wire logic [rsrb_pkg::COUNT_W-1:0] rx_queue_count,
	input  wire logic [rsrb_pkg::COUNT_W-1:0] rc_cal_high,
	input  wire logic [rsrb_pkg::COUNT_W-1:0] rc_cal_low,
	input  wire logic [rsrb_pkg::COUNT_W-1:0] link_quality_est
);
	import rsrb_pkg::*;

	logic              sclk_s;
	logic              mosi_s;
	logic              csn_s;
	logic              sclk_q;
	logic              sclk_rise;
	logic              sclk_fall;
	logic              cs_active;
	logic [CODE_W-1:0] prev_code;
	logic [CODE_W-1:0] shown_code;
	logic              asleep;
	logic              rx_entry;
	logic              crc_ok;
	logic              next_crc_ok;
	logic              next_wake;
	rsrb_spi_t         spi_st;
	rsrb_spi_t         next_spi_st;
	logic [CNT_W-1:0]  bit_cnt;
	logic [CNT_W-1:0]  next_bit_cnt;
	logic [BYTE_W-1:0] rx_shift;
	logic [BYTE_W-1:0] next_rx_shift;
	logic [BYTE_W-1:0] tx_shift;
	logic [BYTE_W-1:0] next_tx_shift;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] next_addr;
	logic [ADDR_W-1:0] burst_addr;
	logic              is_read;
	logic              next_is_read;
	logic              is_burst;
	logic              next_is_burst;
	logic              next_miso;
	logic [BYTE_W-1:0] hdr;
	logic              load_evt;
	logic [15:0]       wor_q;

	// pin synchronisers; chip select idles high
	rsrb_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h4)
	) u_sync (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pins      ({chip_select_low, spi_sclk, spi_mosi}),
		.pins_sync ({csn_s, sclk_s, mosi_s})
	);

	// link clock edges, seen on the synchronised copy
	assign sclk_rise = sclk_s & ~sclk_q;
	assign sclk_fall = ~sclk_s & sclk_q;
	assign cs_active = ~csn_s;

	// radio state as shown: sleep codes never reach the host
	assign asleep     = (radio_fsm_code == CODE_SLEEP) ||
	                    (radio_fsm_code == CODE_CRYSTAL_OFF_STATE);
	assign shown_code = asleep ? CODE_IDLE : radio_fsm_code;

	// receive mode entered or restarted
	assign rx_entry = ((radio_fsm_code == CODE_RX) &&
	                   (prev_code != CODE_RX)) ||
	                  ((radio_fsm_code == CODE_RX_RST) &&
	                   (prev_code != CODE_RX_RST));

	// status byte for one address; unmapped addresses read zero
	function automatic logic [BYTE_W-1:0] status_of(
		input logic [ADDR_W-1:0] a
	);
		logic [BYTE_W-1:0] b;
		b = BYTE_ZERO;
		case (a)
			ADDR_FSM_STATE: b[CODE_W-1:0] = shown_code;
			ADDR_WOR_HIGH:  b = wor_time[15:8];
			ADDR_WOR_LOW:   b = wor_time[7:0];
			ADDR_PKT_FLAGS: begin
				b[PKT_CRC_BIT]  = crc_ok;
				b[PKT_CS_BIT]   = carrier_sense;
				b[PKT_PQT_BIT]  = preamble_quality_met;
				b[PKT_CCA_BIT]  = channel_clear_flag;
				b[PKT_SYNC_BIT] = sync_found_flag;
				b[PKT_GP2_BIT]  = gp_output_two_level;
				b[PKT_GP0_BIT]  = gp_output_zero_level;
			end
			ADDR_SYNTH_DAC: b = synth_cal_dac;
			ADDR_TX_FILL:   b = {tx_queue_underrun, tx_queue_count};
			ADDR_RX_FILL:   b = {rx_queue_overrun, rx_queue_count};
			ADDR_RC_CAL_HI: b[COUNT_W-1:0] = rc_cal_high;
			ADDR_RC_CAL_LO: b[COUNT_W-1:0] = rc_cal_low;
			ADDR_LINK_QUAL: b = {crc_ok, link_quality_est};
			default:        b = BYTE_ZERO;
		endcase
		return b;
	endfunction : status_of

	// crc flag and wake request
	always_comb begin
		// a finished check wins over a receive restart in the same cycle
		if (crc_check_done) begin
			next_crc_ok = crc_check_match;
		end else if (rx_entry) begin
			next_crc_ok = 1'b0;
		end else begin
			next_crc_ok = crc_ok;
		end
		next_wake = cs_active && asleep;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_ok       <= 1'b0;
			wake_to_idle <= 1'b0;
			prev_code    <= CODE_SLEEP;
			sclk_q       <= 1'b0;
		end else begin
			crc_ok       <= next_crc_ok;
			wake_to_idle <= next_wake;
			prev_code    <= radio_fsm_code;
			sclk_q       <= sclk_s;
		end
	end

	// serial port: header byte, then data bytes shifted out msb first
	assign hdr        = {rx_shift[BYTE_W-2:0], mosi_s};
	assign burst_addr = addr_q + ADDR_STEP;
	assign load_evt   = cs_active && (spi_st == SPI_HEADER) &&
	                    sclk_rise && (bit_cnt == BIT_LAST);

	always_comb begin
		next_spi_st   = spi_st;
		next_bit_cnt  = bit_cnt;
		next_rx_shift = rx_shift;
		next_tx_shift = tx_shift;
		next_addr     = addr_q;
		next_is_read  = is_read;
		next_is_burst = is_burst;
		next_miso     = spi_miso_out;
		if (!cs_active) begin
			next_spi_st   = SPI_OFF;
			next_bit_cnt  = BIT_FIRST;
			next_tx_shift = BYTE_ZERO;
			next_miso     = 1'b0;
		end else begin
			unique case (spi_st)
				SPI_OFF: begin
					next_spi_st   = SPI_HEADER;
					next_bit_cnt  = BIT_FIRST;
					next_tx_shift = BYTE_ZERO;
				end
				SPI_HEADER: begin
					if (sclk_rise) begin
						next_rx_shift = hdr;
						next_bit_cnt  = bit_cnt + BIT_STEP;
						if (bit_cnt == BIT_LAST) begin
							next_addr     = hdr[ADDR_W-1:0];
							next_is_read  = hdr[HDR_READ_BIT];
							next_is_burst = hdr[HDR_BURST_BIT];
							next_spi_st   = SPI_DATA;
							// a write header loads nothing
							next_tx_shift = hdr[HDR_READ_BIT] ?
							    status_of(hdr[ADDR_W-1:0]) : BYTE_ZERO;
						end
					end
				end
				SPI_DATA: begin
					if (sclk_rise) begin
						next_rx_shift = hdr;
						next_bit_cnt  = bit_cnt + BIT_STEP;
						if (bit_cnt == BIT_LAST) begin
							if (is_burst) begin
								next_addr     = burst_addr;
								next_tx_shift = is_read ?
								    status_of(burst_addr) : BYTE_ZERO;
							end else begin
								next_spi_st   = SPI_HEADER;
								next_tx_shift = BYTE_ZERO;
							end
						end
					end
				end
			endcase
			// data changes on the falling edge of the link clock
			if (sclk_fall) begin
				next_miso     = tx_shift[BYTE_W-1];
				next_tx_shift = {tx_shift[BYTE_W-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			spi_st       <= SPI_OFF;
			bit_cnt      <= BIT_FIRST;
			rx_shift     <= BYTE_ZERO;
			tx_shift     <= BYTE_ZERO;
			addr_q       <= '0;
			is_read      <= 1'b0;
			is_burst     <= 1'b0;
			spi_miso_out <= 1'b0;
			spi_miso_oe  <= 1'b0;
		end else begin
			spi_st       <= next_spi_st;
			bit_cnt      <= next_bit_cnt;
			rx_shift     <= next_rx_shift;
			tx_shift     <= next_tx_shift;
			addr_q       <= next_addr;
			is_read      <= next_is_read;
			is_burst     <= next_is_burst;
			spi_miso_out <= next_miso;
			spi_miso_oe  <= cs_active;
		end
	end

	// helper copy of the timer for the checks below
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wor_q <= '0;
		end else begin
			wor_q <= wor_time;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_state_fmt;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_FSM_STATE) |=>
		(tx_shift[BYTE_W-1:CODE_W] == '0) &&
		(tx_shift[CODE_W-1:0] == ((prev_code == CODE_SLEEP ||
		  prev_code == CODE_CRYSTAL_OFF_STATE) ? CODE_IDLE : prev_code));
	endproperty
	a_state_fmt: assert property (p_state_fmt)
		else $error("state byte wrong");

	property p_no_sleep_seen;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_FSM_STATE) |=>
		(tx_shift[CODE_W-1:0] != CODE_SLEEP) &&
		(tx_shift[CODE_W-1:0] != CODE_CRYSTAL_OFF_STATE);
	endproperty
	a_no_sleep_seen: assert property (p_no_sleep_seen)
		else $error("sleep code visible");

	property p_wake;
		cs_active && asleep |=> wake_to_idle;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake request");

	property p_wor_high;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_WOR_HIGH) |=> tx_shift == wor_q[15:8];
	endproperty
	a_wor_high: assert property (p_wor_high)
		else $error("timer high byte wrong");

	property p_crc_clear;
		rx_entry && !crc_check_done |=> !crc_ok;
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("crc flag not cleared");

	property p_crc_set;
		crc_check_done |=> crc_ok == $past(crc_check_match);
	endproperty
	a_crc_set: assert property (p_crc_set)
		else $error("crc flag not updated");

	property p_pkt_bits;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_PKT_FLAGS) |=>
		!tx_shift[1] &&
		(tx_shift[PKT_GP2_BIT] == $past(gp_output_two_level)) &&
		(tx_shift[PKT_GP0_BIT] == $past(gp_output_zero_level));
	endproperty
	a_pkt_bits: assert property (p_pkt_bits)
		else $error("packet flag byte wrong");

	property p_tx_fill;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_TX_FILL) |=>
		tx_shift == {$past(tx_queue_underrun), $past(tx_queue_count)};
	endproperty
	a_tx_fill: assert property (p_tx_fill)
		else $error("tx fill byte wrong");

	property p_rc_rsv;
		load_evt && hdr[HDR_READ_BIT] &&
		((hdr[ADDR_W-1:0] == ADDR_RC_CAL_HI) ||
		 (hdr[ADDR_W-1:0] == ADDR_RC_CAL_LO)) |=> !tx_shift[FLAG_BIT];
	endproperty
	a_rc_rsv: assert property (p_rc_rsv)
		else $error("oscillator reserved bit set");

	property p_lqi_mirror;
		load_evt && hdr[HDR_READ_BIT] &&
		(hdr[ADDR_W-1:0] == ADDR_LINK_QUAL) |=>
		tx_shift[FLAG_BIT] == $past(crc_ok);
	endproperty
	a_lqi_mirror: assert property (p_lqi_mirror)
		else $error("link quality crc bit wrong");

	property p_write_quiet;
		(spi_st == SPI_DATA) && !is_read |-> !spi_miso_out;
	endproperty
	a_write_quiet: assert property (p_write_quiet)
		else $error("data driven on write");

	c_burst_read: cover property (load_evt && hdr[HDR_READ_BIT] &&
		hdr[HDR_BURST_BIT]);
	c_write: cover property (load_evt && !hdr[HDR_READ_BIT]);
	c_wake: cover property (wake_to_idle);
	c_crc_ok: cover property (crc_check_done && crc_check_match);

endmodule : rsrb_top

// *** hw/rsrb_pkg.sv ***
// rsrb_pkg: constants shared by the radio status register bank.
// assumes: 8-bit serial register port, 6-bit register addresses.
package rsrb_pkg;

	// widths
	localparam int BYTE_W  = 8;
	localparam int ADDR_W  = 6;
	localparam int CODE_W  = 5;
	localparam int COUNT_W = 7;
	localparam int CNT_W   = 3;

	// register addresses (status space, reached with or without the burst bit)
	localparam logic [ADDR_W-1:0] ADDR_LINK_QUAL  = 6'h33;
	localparam logic [ADDR_W-1:0] ADDR_FSM_STATE  = 6'h35;
	localparam logic [ADDR_W-1:0] ADDR_WOR_HIGH   = 6'h36;
	localparam logic [ADDR_W-1:0] ADDR_WOR_LOW    = 6'h37;
	localparam logic [ADDR_W-1:0] ADDR_PKT_FLAGS  = 6'h38;
	localparam logic [ADDR_W-1:0] ADDR_SYNTH_DAC  = 6'h39;
	localparam logic [ADDR_W-1:0] ADDR_TX_FILL    = 6'h3a;
	localparam logic [ADDR_W-1:0] ADDR_RX_FILL    = 6'h3b;
	localparam logic [ADDR_W-1:0] ADDR_RC_CAL_HI  = 6'h3c;
	localparam logic [ADDR_W-1:0] ADDR_RC_CAL_LO  = 6'h3d;
	localparam logic [ADDR_W-1:0] ADDR_STEP       = 6'h01;

	// header byte layout
	localparam int HDR_READ_BIT  = 7;
	localparam int HDR_BURST_BIT = 6;

	// packet flag bit positions
	localparam int PKT_CRC_BIT  = 7;
	localparam int PKT_CS_BIT   = 6;
	localparam int PKT_PQT_BIT  = 5;
	localparam int PKT_CCA_BIT  = 4;
	localparam int PKT_SYNC_BIT = 3;
	localparam int PKT_GP2_BIT  = 2;
	localparam int PKT_GP0_BIT  = 0;

	// flag bit of fill and link quality bytes
	localparam int FLAG_BIT = 7;

	// radio control state codes; calibration and settling codes lie between
	localparam logic [CODE_W-1:0] CODE_SLEEP   = 5'h00;
	localparam logic [CODE_W-1:0] CODE_IDLE    = 5'h01;
	localparam logic [CODE_W-1:0] CODE_CRYSTAL_OFF_STATE    = 5'h02;
	localparam logic [CODE_W-1:0] CODE_RX      = 5'h0d;
	localparam logic [CODE_W-1:0] CODE_RX_RST  = 5'h0f;
	localparam logic [CODE_W-1:0] CODE_RX_OVF  = 5'h11;
	localparam logic [CODE_W-1:0] CODE_TX      = 5'h13;
	localparam logic [CODE_W-1:0] CODE_TX_UNF  = 5'h16;

	// serial port counters and fills
	localparam logic [CNT_W-1:0]  BIT_LAST  = 3'h7;
	localparam logic [CNT_W-1:0]  BIT_STEP  = 3'h1;
	localparam logic [CNT_W-1:0]  BIT_FIRST = 3'h0;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	// serial port phases
	typedef enum logic [1:0] {SPI_OFF, SPI_HEADER, SPI_DATA} rsrb_spi_t;

endpackage : rsrb_pkg

// *** hw/rsrb_sync.sv ***
// rsrb_sync: two-flop synchroniser for a group of pin inputs.
// assumes: inputs are independent levels from outside sys_clk.
`timescale 1ns/1ps
module rsrb_sync #(
	parameter int              WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] pins_sync
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta      <= RST_VAL;
			pins_sync <= RST_VAL;
		end else begin
			meta      <= pins;
			pins_sync <= meta;
		end
	end

endmodule : rsrb_sync

// *** sim/rsrb_host.sv ***
// rsrb_host: host side of the serial register port, mode 0, msb first.
// assumes: the bench calls frame(); the link clock exists only in frames.
`timescale 1ns/1ps
module rsrb_host #(
	parameter int HALF = 200
) (
	output logic       chip_select_low,
	output logic       spi_sclk,
	output logic       spi_mosi,
	input  wire logic  spi_miso_out,
	input  wire logic  spi_miso_oe,
	output logic [7:0] rd_data,
	output logic       rd_strobe
);
	logic mlast;

	// pins idle: deselected, clock parked low between frames
	initial begin
		chip_select_low = 1'b1;
		spi_sclk = 1'b0;
		spi_mosi = 1'b1;
		rd_data = 8'h00;
		rd_strobe = 1'b0;
		mlast = 1'b0;
	end

	// one byte each way; miso taken late in the high phase, where it is
	// settled; a released line reads as the inverse of its last value
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = tx[i];
			#HALF spi_sclk = 1'b1;
			#HALF mlast = spi_miso_oe ? spi_miso_out : ~mlast;
			rx[i] = mlast;
			spi_sclk = 1'b0;
		end
	endtask : shift

	// header then n data bytes; only register bytes are read, the output
	// levels are never polled for lock indication
	task automatic frame(input logic [7:0] hdr, input int n,
		input logic [7:0] wd);
		logic [7:0] rx;
		#13 chip_select_low = 1'b0;
		#HALF;
		shift(hdr, rx);
		for (int k = 0; k < n; k++) begin
			shift(wd + 8'(k), rx);
			rd_data = rx;
			rd_strobe = 1'b1;
			#1 rd_strobe = 1'b0;
		end
		#HALF chip_select_low = 1'b1;
		spi_mosi = ~spi_mosi;
		#(2 * HALF);
	endtask : frame
endmodule : rsrb_host

// *** sim/tb.sv ***
// tb: reads the radio status bank through the host model, checks bytes.
// assumes: rsrb_pkg, rsrb_top and rsrb_host are compiled first.
`timescale 1ns/1ps
module tb;
	import rsrb_pkg::*;
	logic               sys_clk, rst_n, chip_select_low, spi_sclk, spi_mosi;
	logic               spi_miso_out, spi_miso_oe, wake_to_idle, wexp;
	logic [CODE_W-1:0]  radio_fsm_code;
	logic [15:0]        wor_time;
	logic               crc_check_done, crc_check_match, carrier_sense;
	logic               preamble_quality_met, channel_clear_flag;
	logic               sync_found_flag, gp_output_two_level;
	logic               gp_output_zero_level, tx_queue_underrun;
	logic               rx_queue_overrun, rd_strobe, crc_m;
	logic [BYTE_W-1:0]  synth_cal_dac, rd_data, e;
	logic [COUNT_W-1:0] tx_queue_count, rx_queue_count, rc_cal_high;
	logic [COUNT_W-1:0] rc_cal_low, link_quality_est;
	logic [31:0]        seed;
	logic [BYTE_W-1:0]  exp_q[$];
	logic [CODE_W-1:0]  codes[10] = '{CODE_SLEEP, CODE_IDLE, CODE_CRYSTAL_OFF_STATE,
		5'h03, CODE_RX, CODE_RX_RST, CODE_RX_OVF, CODE_TX, CODE_TX_UNF, 5'h14};
	int                 errors, tests_run, cycles;

	rsrb_top dut_u (
		.sys_clk              (sys_clk),
		.rst_n                (rst_n),
		.chip_select_low      (chip_select_low),
		.spi_sclk             (spi_sclk),
		.spi_mosi             (spi_mosi),
		.spi_miso_out         (spi_miso_out),
		.spi_miso_oe          (spi_miso_oe),
		.wake_to_idle         (wake_to_idle),
		.radio_fsm_code       (radio_fsm_code),
		.wor_time             (wor_time),
		.crc_check_done       (crc_check_done),
		.crc_check_match      (crc_check_match),
		.carrier_sense        (carrier_sense),
		.preamble_quality_met (preamble_quality_met),
		.channel_clear_flag   (channel_clear_flag),
		.sync_found_flag      (sync_found_flag),
		.gp_output_two_level  (gp_output_two_level),
		.gp_output_zero_level (gp_output_zero_level),
		.synth_cal_dac        (synth_cal_dac),
		.tx_queue_underrun    (tx_queue_underrun),
		.tx_queue_count       (tx_queue_count),
		.rx_queue_overrun     (rx_queue_overrun),
		.rx_queue_count       (rx_queue_count),
		.rc_cal_high          (rc_cal_high),
		.rc_cal_low           (rc_cal_low),
		.link_quality_est     (link_quality_est)
	);
	rsrb_host host_u (.chip_select_low(chip_select_low),
		.spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
		.rd_data(rd_data), .rd_strobe(rd_strobe));

	// 20 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction : lfsr

	// expected byte of one address, built from the live inputs
	function automatic logic [7:0] exp_reg(input logic [ADDR_W-1:0] a);
		logic [CODE_W-1:0] c;
		c = radio_fsm_code;
		if (c == CODE_SLEEP || c == CODE_CRYSTAL_OFF_STATE)
			c = CODE_IDLE;
		case (a)
			ADDR_LINK_QUAL: return {crc_m, link_quality_est};
			ADDR_FSM_STATE: return {3'h0, c};
			ADDR_WOR_HIGH:  return wor_time[15:8];
			ADDR_WOR_LOW:   return wor_time[7:0];
			ADDR_PKT_FLAGS: return {crc_m, carrier_sense,
				preamble_quality_met, channel_clear_flag, sync_found_flag,
				gp_output_two_level, 1'b0, gp_output_zero_level};
			ADDR_SYNTH_DAC: return synth_cal_dac;
			ADDR_TX_FILL:   return {tx_queue_underrun, tx_queue_count};
			ADDR_RX_FILL:   return {rx_queue_overrun, rx_queue_count};
			ADDR_RC_CAL_HI: return {1'b0, rc_cal_high};
			ADDR_RC_CAL_LO: return {1'b0, rc_cal_low};
			default:        return BYTE_ZERO;
		endcase
	endfunction : exp_reg

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk

	task automatic rand_inputs;
		logic [31:0] a, b, c;
		a = lfsr(seed);
		b = lfsr(a);
		c = lfsr(b);
		seed = c;
		@(posedge sys_clk);
		wor_time <= a[15:0];
		synth_cal_dac <= a[23:16];
		link_quality_est <= a[30:24];
		tx_queue_count <= b[6:0];
		rx_queue_count <= b[13:7];
		rc_cal_high <= b[20:14];
		rc_cal_low <= b[27:21];
		{carrier_sense, preamble_quality_met} <= c[1:0];
		{channel_clear_flag, sync_found_flag} <= c[3:2];
		{gp_output_two_level, gp_output_zero_level} <= c[5:4];
		{tx_queue_underrun, rx_queue_overrun} <= c[7:6];
		@(posedge sys_clk);
	endtask : rand_inputs

	// new state code with an optional check result in the same cycle
	task automatic step(input logic d, input logic m,
		input logic [CODE_W-1:0] c);
		@(posedge sys_clk);
		if (c != radio_fsm_code && (c == CODE_RX || c == CODE_RX_RST))
			crc_m = 1'b0;
		if (d)
			crc_m = m;
		radio_fsm_code <= c;
		crc_check_done <= d;
		crc_check_match <= m;
		@(posedge sys_clk);
		crc_check_done <= 1'b0;
		@(posedge sys_clk);
	endtask : step

	task automatic rd_burst(input logic [ADDR_W-1:0] a, input int n);
		for (int k = 0; k < n; k++)
			exp_q.push_back(exp_reg(ADDR_W'(a + k)));
		host_u.frame({2'b11, a}, n, BYTE_ZERO);
	endtask : rd_burst

	task automatic results;
		$display("checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// every byte the host reads is matched against the oldest note
	always @(posedge rd_strobe) begin
		if (exp_q.size() == 0) begin
			errors++;
			$display("wrong value at %0t: unexpected byte", $time);
		end else begin
			e = exp_q.pop_front();
			chk(rd_data, e);
		end
	end

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("wrong value at %0t: run too long", $time);
			results();
		end
	end

	// main sequence
	initial begin
		{rst_n, crc_check_done, crc_check_match, crc_m} = 4'h0;
		radio_fsm_code = CODE_IDLE;
		seed = 32'h003f;
		rand_inputs();
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		repeat (4) begin
			rand_inputs();
			rd_burst(ADDR_LINK_QUAL, 13);
		end
		rd_burst(6'h3e, 4);
		// single read without the burst bit
		exp_q.push_back(exp_reg(ADDR_WOR_LOW));
		host_u.frame({2'b10, ADDR_WOR_LOW}, 1, BYTE_ZERO);
		$display("test register map done");
		foreach (codes[i]) begin
			step(1'b0, 1'b0, codes[i]);
			wexp = codes[i] == CODE_SLEEP || codes[i] == CODE_CRYSTAL_OFF_STATE;
			fork
				rd_burst(ADDR_FSM_STATE, 1);
				begin
					repeat (12) @(posedge sys_clk);
					chk({7'h0, wake_to_idle}, {7'h0, wexp});
				end
			join
		end
		$display("test state codes done");
		step(1'b1, 1'b1, CODE_IDLE);
		rd_burst(ADDR_PKT_FLAGS, 1);
		step(1'b0, 1'b0, CODE_RX);
		rd_burst(ADDR_PKT_FLAGS, 1);
		step(1'b1, 1'b1, CODE_RX);
		step(1'b0, 1'b0, CODE_RX_RST);
		rd_burst(ADDR_LINK_QUAL, 1);
		step(1'b1, 1'b1, CODE_IDLE);
		step(1'b1, 1'b1, CODE_RX);
		rd_burst(ADDR_LINK_QUAL, 1);
		step(1'b1, 1'b0, CODE_RX);
		rd_burst(ADDR_PKT_FLAGS, 1);
		$display("test check flag done");
		rand_inputs();
		repeat (3) exp_q.push_back(BYTE_ZERO);
		host_u.frame(8'h75, 3, 8'ha5);
		rd_burst(ADDR_LINK_QUAL, 13);
		$display("test write refusal done");
		repeat (20) @(posedge sys_clk);
		chk(8'(exp_q.size()), 8'h00);
		results();
	end
endmodule : tb
